/* File: dtc_pkg.sv */
/*
 * dtc_pkg: shared constants and types for the converter trim and calibration
 * clock register bank (register indices, field positions, reset values, codes).
 * Assumes byte address = 4 * register index on a 32-bit AXI4-Lite bus.
 */
package dtc_pkg;

   // register indices, byte address is four times the index
   localparam logic [9:0] IDX_PAGE      = 10'h008;
   localparam logic [9:0] IDX_CAL_STAT  = 10'h052;
   localparam logic [9:0] IDX_FSC_LOW   = 10'h059;
   localparam logic [9:0] IDX_FSC_HIGH  = 10'h05a;
   localparam logic [9:0] IDX_CAL_TUNE  = 10'h061;
   localparam logic [9:0] IDX_CLK_GATE  = 10'h081;
   localparam logic [9:0] IDX_RING_OSC  = 10'h083;
   localparam logic [9:0] IDX_SYSREF    = 10'h084;

   // field positions
   localparam int POS_TUNE_A     = 6;
   localparam int POS_TUNE_B     = 5;
   localparam int POS_TUNE_C     = 3;
   localparam int POS_RO_CTRL    = 7;
   localparam int POS_COUPLING   = 6;
   localparam int POS_CAL_DONE   = 0;

   // reset values
   localparam logic [1:0] RST_PAGE       = 2'h3;
   localparam logic [5:0] RST_FSC_LOW_RS = 6'h0a;
   localparam logic [1:0] RST_FSC_LOW    = 2'h0;
   localparam logic [7:0] RST_FSC_HIGH   = 8'h28;
   localparam logic [7:0] RST_CAL_TUNE   = 8'h60;
   localparam logic [7:0] RST_CLK_GATE   = 8'h00;
   localparam logic [1:0] RST_RO_DIV     = 2'h2;
   localparam logic [7:0] RST_SYSREF     = 8'h00;

   // full-scale current in units of 1/1024 mA: 16 mA base, 25/1024 mA per code
   localparam logic [15:0] FSC_BASE_Q1024 = 16'h4000;
   localparam logic [5:0]  FSC_STEP_Q1024 = 6'h19;

   // ring oscillator divide ratio is 8 shifted left by the code
   localparam logic [6:0] RO_DIV_BASE = 7'h08;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [9:0]  code;      // full-scale code
      logic [15:0] current;   // full-scale current, 1/1024 mA units
   } dtc_dac_ctrl_t;

endpackage : dtc_pkg

/* File: dtc_regs.sv */
/*
 * dtc_regs: AXI4-Lite register bank for full-scale current trim (paged per
 * converter), calibration tuning bits, calibration clock gating, ring
 * oscillator divider and sysref coupling select.
 * Assumes cal_done_in comes from the calibration engine on ref_clk_in.
 */
// Implementation choice: the AXI4-Lite slave port.
// Contract
// RL1: full-scale code is 10 bits, low two in low register, upper eight in high.
// RL2: full-scale code is paged by converter page select register.
// RL3: full-scale current equals 16 mA plus code times 25/1024 mA.
// RL4: software writes ones to tuning bits 6, 5, 3; bit 3 resets cleared.
// RL5: after calibration completes software sets clock-off bit; device stops that clock.
// RL6: divider codes 00..11 select 8, 16, 32, 64; reset code is 2.
// RL7: sysref coupling bit 6: zero AC, one DC; resets cleared.
// RL8: calibration status bit 0 reads one when paged converter finished calibration.
// RL9: software writes nothing in calibration range while calibration is active.
// RL10: reserved writes do nothing functional; read-only reserved bits read zero.
`timescale 1ns/1ps
module dtc_regs #(
   parameter int ADDR_W = 12
) (
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_in,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
   input  wire logic                  s_axi_awvalid_in,
   output logic                       s_axi_awready_out,
   input  wire logic [31:0]           s_axi_wdata_in,
   input  wire logic [3:0]            s_axi_wstrb_in,
   input  wire logic                  s_axi_wvalid_in,
   output logic                       s_axi_wready_out,
   output logic [1:0]                 s_axi_bresp_out,
   output logic                       s_axi_bvalid_out,
   input  wire logic                  s_axi_bready_in,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr_in,
   input  wire logic                  s_axi_arvalid_in,
   output logic                       s_axi_arready_out,
   output logic [31:0]                s_axi_rdata_out,
   output logic [1:0]                 s_axi_rresp_out,
   output logic                       s_axi_rvalid_out,
   input  wire logic                  s_axi_rready_in,
   input  wire logic [1:0]            cal_done_in,
   output dtc_pkg::dtc_dac_ctrl_t [1:0] dac_ctrl_out,
   output logic [1:0]                 cal_clk_off_out,
   output logic [2:0]                 cal_tune_out,
   output logic [6:0]                 ring_osc_div_ratio_out,
   output logic                       ring_osc_control_bit_out,
   output logic                       sysref_dc_couple_out
);

   // index decode needs ten index bits above the byte offset
   if (ADDR_W < 12)
   begin : g_chk
      $error("dtc_regs: ADDR_W must be at least 12");
   end

   // ---------------- write channel holding ----------------
   logic              aw_full_q;
   logic              w_full_q;
   logic [9:0]        aw_idx_q;
   logic [7:0]        w_byte_q;
   logic              w_lane0_q;
   logic              aw_rdy_q;
   logic              w_rdy_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              aw_full_d;
   logic              w_full_d;
   logic              bvalid_d;

   wire aw_take = s_axi_awvalid_in & aw_rdy_q;
   wire w_take  = s_axi_wvalid_in & w_rdy_q;
   wire wr_go   = aw_full_q & w_full_q & ~bvalid_q;
   wire b_done  = bvalid_q & s_axi_bready_in;

   // per-index write strobes; only byte lane 0 carries register data
   wire wr_en       = wr_go & w_lane0_q;
   wire wr_page     = wr_en & (aw_idx_q == dtc_pkg::IDX_PAGE);
   wire wr_fsc_low  = wr_en & (aw_idx_q == dtc_pkg::IDX_FSC_LOW);
   wire wr_fsc_high = wr_en & (aw_idx_q == dtc_pkg::IDX_FSC_HIGH);
   wire wr_tune     = wr_en & (aw_idx_q == dtc_pkg::IDX_CAL_TUNE);
   wire wr_clk      = wr_en & (aw_idx_q == dtc_pkg::IDX_CLK_GATE);
   wire wr_ro       = wr_en & (aw_idx_q == dtc_pkg::IDX_RING_OSC);
   wire wr_sys      = wr_en & (aw_idx_q == dtc_pkg::IDX_SYSREF);

   // status is read-only, a write there is accepted and ignored
   wire wr_mapped = (aw_idx_q == dtc_pkg::IDX_PAGE)     | (aw_idx_q == dtc_pkg::IDX_CAL_STAT) |
                    (aw_idx_q == dtc_pkg::IDX_FSC_LOW)  | (aw_idx_q == dtc_pkg::IDX_FSC_HIGH) |
                    (aw_idx_q == dtc_pkg::IDX_CAL_TUNE) | (aw_idx_q == dtc_pkg::IDX_CLK_GATE) |
                    (aw_idx_q == dtc_pkg::IDX_RING_OSC) | (aw_idx_q == dtc_pkg::IDX_SYSREF);

   // next state of the write handshake; ready drops while a word is held
   always_comb
   begin
      aw_full_d = (aw_full_q | aw_take) & ~wr_go;
      w_full_d  = (w_full_q | w_take) & ~wr_go;
      bvalid_d  = (bvalid_q & ~b_done) | wr_go;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         aw_rdy_q  <= 1'b0;
         w_rdy_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= dtc_pkg::RESP_OKAY;
         aw_idx_q  <= 10'h000;
         w_byte_q  <= 8'h00;
         w_lane0_q <= 1'b0;
      end
      else
      begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         aw_rdy_q  <= ~aw_full_d & ~bvalid_d;
         w_rdy_q   <= ~w_full_d & ~bvalid_d;
         bvalid_q  <= bvalid_d;
         if (wr_go)
            bresp_q <= wr_mapped ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
         if (aw_take)
            aw_idx_q <= s_axi_awaddr_in[11:2];
         if (w_take)
         begin
            w_byte_q  <= s_axi_wdata_in[7:0];
            w_lane0_q <= s_axi_wstrb_in[0];
         end
      end
   end

   // ---------------- register storage ----------------
   logic [1:0]  page_q;          // one bit per converter, both may be selected
   logic [5:0]  fsc_low_rsvd_q;  // reserved storage, no functional effect
   logic [7:0]  tune_q;
   logic [7:0]  clk_gate_q;
   logic        ro_ctrl_q;
   logic [1:0]  ro_div_q;
   logic [7:0]  sysref_q;
   logic [9:0]  fsc_code_q [2];

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         page_q         <= dtc_pkg::RST_PAGE;
         fsc_low_rsvd_q <= dtc_pkg::RST_FSC_LOW_RS;
         tune_q         <= dtc_pkg::RST_CAL_TUNE;           // [RL4]
         clk_gate_q     <= dtc_pkg::RST_CLK_GATE;
         ro_ctrl_q      <= 1'b0;
         ro_div_q       <= dtc_pkg::RST_RO_DIV;             // [RL6]
         sysref_q       <= dtc_pkg::RST_SYSREF;             // [RL7]
      end
      else
      begin
         if (wr_page)
            page_q <= w_byte_q[1:0];                        // [RL2]
         if (wr_fsc_low)
            fsc_low_rsvd_q <= w_byte_q[7:2];                // [RL10]
         if (wr_tune)
            tune_q <= w_byte_q;
         if (wr_clk)
            clk_gate_q <= w_byte_q;                         // [RL5]
         if (wr_ro)
         begin
            ro_ctrl_q <= w_byte_q[dtc_pkg::POS_RO_CTRL];
            ro_div_q  <= w_byte_q[1:0];                     // bits 6:2 are read-only [RL10]
         end
         if (wr_sys)
            sysref_q <= w_byte_q;
      end
   end

   // one copy of the full-scale code per converter, written when its page bit is set
   for (genvar g = 0; g < 2; g++)
   begin : g_dac
      always_ff @(posedge ref_clk_in)
      begin
         if (rst_in)
            fsc_code_q[g] <= {dtc_pkg::RST_FSC_HIGH, dtc_pkg::RST_FSC_LOW};
         else if (wr_fsc_low & page_q[g])
            fsc_code_q[g][1:0] <= w_byte_q[1:0];           // [RL1] [RL2]
         else if (wr_fsc_high & page_q[g])
            fsc_code_q[g][9:2] <= w_byte_q;                 // [RL1] [RL2]
      end

      // code and current both follow the stored code one cycle later; the multiply is small and constant
      always_ff @(posedge ref_clk_in)
      begin
         if (rst_in)
            dac_ctrl_out[g] <= '0;
         else
         begin
            dac_ctrl_out[g].code    <= fsc_code_q[g];
            dac_ctrl_out[g].current <= dtc_pkg::FSC_BASE_Q1024
                                       + 16'(fsc_code_q[g] * dtc_pkg::FSC_STEP_Q1024); // [RL3]
         end
      end
   end

   // ---------------- read path ----------------
   logic        ar_rdy_q;
   logic        rvalid_q;
   logic [7:0]  rdata_q;
   logic [1:0]  rresp_q;

   wire [9:0] rd_idx  = s_axi_araddr_in[11:2];
   wire       ar_take = s_axi_arvalid_in & ar_rdy_q;
   wire       r_done  = rvalid_q & s_axi_rready_in;

   // reads of a paged field return the lowest selected converter
   wire       rd_sel  = ~page_q[0];
   wire [9:0] rd_code = fsc_code_q[rd_sel];
   wire       rd_done = cal_done_in[rd_sel];

   wire hit_page = (rd_idx == dtc_pkg::IDX_PAGE);
   wire hit_stat = (rd_idx == dtc_pkg::IDX_CAL_STAT);
   wire hit_flo  = (rd_idx == dtc_pkg::IDX_FSC_LOW);
   wire hit_fhi  = (rd_idx == dtc_pkg::IDX_FSC_HIGH);
   wire hit_tune = (rd_idx == dtc_pkg::IDX_CAL_TUNE);
   wire hit_clk  = (rd_idx == dtc_pkg::IDX_CLK_GATE);
   wire hit_ro   = (rd_idx == dtc_pkg::IDX_RING_OSC);
   wire hit_sys  = (rd_idx == dtc_pkg::IDX_SYSREF);
   wire rd_hit   = hit_page | hit_stat | hit_flo | hit_fhi | hit_tune | hit_clk | hit_ro | hit_sys;

   // read mux; unmapped indices read zero
   wire [7:0] rd_byte =
      ({8{hit_page}} & {6'h00, page_q}) |
      ({8{hit_stat}} & (8'(rd_done) << dtc_pkg::POS_CAL_DONE)) |   // [RL8]
      ({8{hit_flo}}  & {fsc_low_rsvd_q, rd_code[1:0]}) |
      ({8{hit_fhi}}  & rd_code[9:2]) |
      ({8{hit_tune}} & tune_q) |
      ({8{hit_clk}}  & clk_gate_q) |
      ({8{hit_ro}}   & {ro_ctrl_q, 5'h00, ro_div_q}) |            // [RL10]
      ({8{hit_sys}}  & sysref_q);

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         ar_rdy_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q  <= 8'h00;
         rresp_q  <= dtc_pkg::RESP_OKAY;
      end
      else if (ar_take)
      begin
         ar_rdy_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q  <= rd_byte;
         rresp_q  <= rd_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      end
      else
      begin
         ar_rdy_q <= ~rvalid_q | r_done;
         rvalid_q <= rvalid_q & ~r_done;
      end
   end

   // ---------------- control outputs ----------------
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         cal_clk_off_out          <= 2'h0;
         cal_tune_out             <= 3'h0;
         ring_osc_div_ratio_out   <= 7'h00;
         ring_osc_control_bit_out <= 1'b0;
         sysref_dc_couple_out     <= 1'b0;
      end
      else
      begin
         // the clock stops only on software request, the device never gates on done alone
         cal_clk_off_out          <= clk_gate_q[1:0];                              // [RL5]
         cal_tune_out             <= {tune_q[dtc_pkg::POS_TUNE_A], tune_q[dtc_pkg::POS_TUNE_B],
                                      tune_q[dtc_pkg::POS_TUNE_C]};
         ring_osc_div_ratio_out   <= dtc_pkg::RO_DIV_BASE << ro_div_q;             // [RL6]
         ring_osc_control_bit_out <= ro_ctrl_q;
         sysref_dc_couple_out     <= sysref_q[dtc_pkg::POS_COUPLING];             // [RL7]
      end
   end

   assign s_axi_awready_out = aw_rdy_q;
   assign s_axi_wready_out  = w_rdy_q;
   assign s_axi_bvalid_out  = bvalid_q;
   assign s_axi_bresp_out   = bresp_q;
   assign s_axi_arready_out = ar_rdy_q;
   assign s_axi_rvalid_out  = rvalid_q;
   assign s_axi_rresp_out   = rresp_q;
   assign s_axi_rdata_out   = {24'h000000, rdata_q};

endmodule : dtc_regs

/* File: dtc_regs_chk.sv */
/*
 * dtc_regs_chk: concurrent checks on the trim and calibration clock register bank.
 * Assumes it is bound to dtc_regs, with one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module dtc_regs_chk #(
   parameter int ADDR_W = 12
) (
   input logic                          ref_clk_in,
   input logic                          rst_in,
   input logic [ADDR_W-1:0]             s_axi_awaddr_in,
   input logic                          s_axi_awvalid_in,
   input logic                          s_axi_awready_out,
   input logic [31:0]                   s_axi_wdata_in,
   input logic [3:0]                    s_axi_wstrb_in,
   input logic                          s_axi_wvalid_in,
   input logic                          s_axi_wready_out,
   input logic [1:0]                    s_axi_bresp_out,
   input logic                          s_axi_bvalid_out,
   input logic [ADDR_W-1:0]             s_axi_araddr_in,
   input logic                          s_axi_arvalid_in,
   input logic                          s_axi_arready_out,
   input logic [31:0]                   s_axi_rdata_out,
   input logic                          s_axi_rvalid_out,
   input logic                          s_axi_rready_in,
   input logic [1:0]                    cal_done_in,
   input dtc_pkg::dtc_dac_ctrl_t [1:0]  dac_ctrl_out,
   input logic [1:0]                    cal_clk_off_out,
   input logic [6:0]                    ring_osc_div_ratio_out,
   input logic                          sysref_dc_couple_out
);
   logic [9:0] wa_q;
   logic [9:0] ra_q;
   logic [7:0] wd_q;
   logic       ws_q;
   // keep the index and data of the access under way; the bus lets them go before the answer
   always_ff @(posedge ref_clk_in)
   begin
      if (s_axi_awvalid_in && s_axi_awready_out) wa_q <= s_axi_awaddr_in[11:2];
      if (s_axi_wvalid_in && s_axi_wready_out) wd_q <= s_axi_wdata_in[7:0];
      if (s_axi_wvalid_in && s_axi_wready_out) ws_q <= s_axi_wstrb_in[0];
      if (s_axi_arvalid_in && s_axi_arready_out) ra_q <= s_axi_araddr_in[11:2];
   end
   // an accepted write with the low byte enabled
   wire wr_ok = s_axi_bvalid_out && s_axi_bresp_out == dtc_pkg::RESP_OKAY && ws_q;
   wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   a_div_ratio: assert property ($rose(wr_ok) && wa_q == dtc_pkg::IDX_RING_OSC
      |-> ##[0:2] ring_osc_div_ratio_out == (7'h08 << wd_q[1:0])) else $error("divider ratio");
   a_clk_off: assert property ($rose(wr_ok) && wa_q == dtc_pkg::IDX_CLK_GATE
      |-> ##[0:2] cal_clk_off_out == wd_q[1:0]) else $error("clock off bits");
   a_couple_sel: assert property ($rose(wr_ok) && wa_q == dtc_pkg::IDX_SYSREF
      |-> ##[0:2] sysref_dc_couple_out == wd_q[6]) else $error("coupling select");
   a_cur_formula: assert property (!$past(rst_in) && !$past(rst_in, 2)
      |-> dac_ctrl_out[0].current == 16'h4000 + 16'h0019 * dac_ctrl_out[0].code
      && dac_ctrl_out[1].current == 16'h4000 + 16'h0019 * dac_ctrl_out[1].code)
      else $error("full-scale current");
   a_rsvd_zero: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
      else $error("upper read bits");
   a_ro_rsvd: assert property (s_axi_rvalid_out && ra_q == dtc_pkg::IDX_RING_OSC
      |-> s_axi_rdata_out[6:2] == 5'h00) else $error("ring reserved bits");
   a_stat_done: assert property (ar_hs && cal_done_in[0] == cal_done_in[1]
      && s_axi_araddr_in[11:2] == dtc_pkg::IDX_CAL_STAT
      |=> s_axi_rdata_out[0] == $past(cal_done_in[0])) else $error("done flag");
   a_rd_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data held");

   c_ring_wr: cover property ($rose(wr_ok) && wa_q == dtc_pkg::IDX_RING_OSC);
   c_stat_one: cover property (s_axi_rvalid_out && ra_q == dtc_pkg::IDX_CAL_STAT && s_axi_rdata_out[0]);
   c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == dtc_pkg::RESP_SLVERR);
endmodule : dtc_regs_chk

bind dtc_regs dtc_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

/* File: tb_top.sv */
/*
 * tb_top: directed AXI4-Lite register tests for dtc_regs.
 * Assumes a 100 MHz clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module tb_top;
   logic ref_clk_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
   logic s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
   logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, ring_osc_control_bit_out;
   logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
   logic [3:0] s_axi_wstrb_in;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, cal_done_in, cal_clk_off_out;
   logic [2:0] cal_tune_out;
   logic [6:0] ring_osc_div_ratio_out;
   logic sysref_dc_couple_out;
   dtc_pkg::dtc_dac_ctrl_t [1:0] dac_ctrl_out;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int r_wait = 0;

   dtc_regs #(.ADDR_W(12)) dut_u (.*);

   // free-running clock
   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   // a hung handshake ends the run here; the tests need well under a thousand cycles
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_errors++;
         $display("wrong value at %0t: handshake timed out", $time);
         test_done();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // one write: address and data offered together, each released when taken
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge ref_clk_in);
      s_axi_awaddr_in <= {idx, 2'h0};
      s_axi_wdata_in <= {24'h000000, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      while (!(a && w))
      begin
         @(posedge ref_clk_in);
         if (!a && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (!a && s_axi_awready_out) a = 1'b1;
         if (!w && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
         if (!w && s_axi_wready_out) w = 1'b1;
      end
      do @(posedge ref_clk_in); while (!s_axi_bvalid_out);
      s_axi_bready_in <= 1'b0;
      cmp({30'h0, s_axi_bresp_out}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
      @(posedge ref_clk_in);
      s_axi_araddr_in <= {idx, 2'h0};
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= (r_wait == 0);
      do @(posedge ref_clk_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 1'b0;
      // a slow reader keeps rready low for r_wait edges, so the slave must hold its answer
      if (r_wait > 0)
      begin
         repeat (r_wait) @(posedge ref_clk_in);
         s_axi_rready_in <= 1'b1;
      end
      do @(posedge ref_clk_in); while (!s_axi_rvalid_out);
      s_axi_rready_in <= 1'b0;
      cmp(s_axi_rdata_out, {24'h000000, e});
      cmp({30'h0, s_axi_rresp_out}, {30'h0, er});
   endtask : rd

   // outputs follow a register write one edge later, so let two edges pass
   task automatic settle();
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask : settle

   function automatic logic [31:0] cur(input int c);
      return 32'(16384 + 25 * c);
   endfunction : cur

   // main sequence
   initial
   begin
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
      {s_axi_arvalid_in, s_axi_rready_in, cal_done_in} = 4'h0;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 56'h0;
      s_axi_wstrb_in = 4'h1;
      rst_in = 1'b1;
      repeat (12) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      settle();
      rd(dtc_pkg::IDX_FSC_HIGH, 8'h28, dtc_pkg::RESP_OKAY);
      rd(dtc_pkg::IDX_FSC_LOW, 8'h28, dtc_pkg::RESP_OKAY);
      rd(dtc_pkg::IDX_CAL_TUNE, 8'h60, dtc_pkg::RESP_OKAY);
      r_wait = 2;
      rd(dtc_pkg::IDX_RING_OSC, 8'h02, dtc_pkg::RESP_OKAY);
      r_wait = 0;
      rd(dtc_pkg::IDX_SYSREF, 8'h00, dtc_pkg::RESP_OKAY);
      cmp(dac_ctrl_out[1].current, cur(160));
      cmp(cal_tune_out, 32'h6);
      cmp(ring_osc_div_ratio_out, 32'h20);
      // every divider code, with reserved bits written high
      for (int c = 0; c < 4; c++)
      begin
         wr(dtc_pkg::IDX_RING_OSC, 8'hfc | 8'(c), dtc_pkg::RESP_OKAY);
         settle();
         rd(dtc_pkg::IDX_RING_OSC, 8'h80 | 8'(c), dtc_pkg::RESP_OKAY);
         cmp(ring_osc_div_ratio_out, 32'h8 << c);
         cmp(ring_osc_control_bit_out, 32'h1);
         wr(dtc_pkg::IDX_CLK_GATE, 8'hf0 | 8'(c), dtc_pkg::RESP_OKAY);
         settle();
         cmp(cal_clk_off_out, c);
      end
      wr(dtc_pkg::IDX_SYSREF, 8'hff, dtc_pkg::RESP_OKAY);
      settle();
      cmp(sysref_dc_couple_out, 32'h1);
      wr(dtc_pkg::IDX_SYSREF, 8'hbf, dtc_pkg::RESP_OKAY);
      settle();
      cmp(sysref_dc_couple_out, 32'h0);
      // low byte lane disabled: the word is answered but must not land
      s_axi_wstrb_in <= 4'h0;
      wr(dtc_pkg::IDX_SYSREF, 8'hff, dtc_pkg::RESP_OKAY);
      s_axi_wstrb_in <= 4'h1;
      settle();
      cmp(sysref_dc_couple_out, 32'h0);
      wr(dtc_pkg::IDX_CAL_TUNE, 8'h68, dtc_pkg::RESP_OKAY);
      settle();
      cmp(cal_tune_out, 32'h7);
      // one code per converter through the page select; no calibration runs meanwhile
      wr(dtc_pkg::IDX_PAGE, 8'h01, dtc_pkg::RESP_OKAY);
      wr(dtc_pkg::IDX_FSC_LOW, 8'h2b, dtc_pkg::RESP_OKAY);
      wr(dtc_pkg::IDX_FSC_HIGH, 8'hff, dtc_pkg::RESP_OKAY);
      wr(dtc_pkg::IDX_PAGE, 8'h02, dtc_pkg::RESP_OKAY);
      wr(dtc_pkg::IDX_FSC_LOW, 8'h29, dtc_pkg::RESP_OKAY);
      wr(dtc_pkg::IDX_FSC_HIGH, 8'h01, dtc_pkg::RESP_OKAY);
      settle();
      cmp(dac_ctrl_out[0].code, 32'h3ff);
      cmp(dac_ctrl_out[0].current, cur(1023));
      cmp(dac_ctrl_out[1].code, 32'h5);
      cmp(dac_ctrl_out[1].current, cur(5));
      rd(dtc_pkg::IDX_FSC_HIGH, 8'h01, dtc_pkg::RESP_OKAY);
      cal_done_in <= 2'h2;
      rd(dtc_pkg::IDX_CAL_STAT, 8'h01, dtc_pkg::RESP_OKAY);
      wr(dtc_pkg::IDX_PAGE, 8'h01, dtc_pkg::RESP_OKAY);
      rd(dtc_pkg::IDX_FSC_HIGH, 8'hff, dtc_pkg::RESP_OKAY);
      rd(dtc_pkg::IDX_CAL_STAT, 8'h00, dtc_pkg::RESP_OKAY);
      cal_done_in <= 2'h3;
      rd(dtc_pkg::IDX_CAL_STAT, 8'h01, dtc_pkg::RESP_OKAY);
      // unmapped index is refused and changes nothing
      wr(10'h3ff, 8'h55, dtc_pkg::RESP_SLVERR);
      rd(10'h3ff, 8'h00, dtc_pkg::RESP_SLVERR);
      test_done();
   end
endmodule : tb_top
